// file: secondary_plane_surface_regs_test.sv
// secondary_plane_surface_regs_test.sv: self-checking bench of spr_regs.
// assumes: spsr_cs_model and spsr_props compiled first.
`default_nettype none
`include "spr_consts.vh"
// ------
// bench
// ------
module secondary_plane_surface_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0, nrst = 1'b0, sw_wr_en = 1'b0, sw_rd_en = 1'b0, pix_valid = 1'b0;
	logic        vsync = 1'b0, vblank = 1'b0, pipe_enabled = 1'b1, ctl_tiled = 1'b0;
	logic        ctl_key_enable = 1'b0, ctl_rotate180 = 1'b0;
	logic [19:0] sw_wr_addr = 20'h00000, sw_rd_addr = 20'h00000, cs_wr_addr;
	logic [31:0] sw_wr_data = 32'h00000000, sw_rd_data, cs_wr_data, first_pix_addr, stride_out;
	logic [23:0] pix_data = 24'h000000;
	logic [11:0] tile_x_out, tile_y_out;
	logic        sw_rd_valid, cs_wr_valid, cs_wr_ready, tile_from_lr, pix_transparent;
	logic        pix_out_valid;
	int          n_mismatch = 0, n_compared = 0;
	bit          ok;
	logic [19:0] offs [7] = '{`SPR_OFF_LIN, `SPR_OFF_STRIDE, `SPR_OFF_KEYVAL,
		`SPR_OFF_KEYMSK, `SPR_OFF_SURF, `SPR_OFF_TILE, `SPR_OFF_FLPQ};
	logic [31:0] full [7] = '{32'hffffffff, 32'hffffffff, 32'h00ffffff, 32'h00ffffff,
		32'h1ffff000, 32'h0fff0fff, 32'h00000701};
	always #50 mclk = ~mclk;
	spr_regs dut_u (.mclk, .nrst, .sw_wr_en, .sw_wr_addr, .sw_wr_data, .sw_rd_en, .sw_rd_addr,
		.sw_rd_data, .sw_rd_valid, .cs_wr_valid, .cs_wr_addr, .cs_wr_data, .cs_wr_ready,
		.vsync, .vblank, .pipe_enabled, .ctl_tiled, .ctl_key_enable, .ctl_rotate180,
		.pix_valid, .pix_data, .first_pix_addr, .stride_out, .tile_x_out, .tile_y_out,
		.tile_from_lr, .pix_transparent, .pix_out_valid);
	spsr_cs_model cs_u (.mclk, .cs_wr_ready, .cs_wr_valid, .cs_wr_addr, .cs_wr_data);
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		@(posedge mclk);
		sw_wr_en <= 1'b1;
		sw_wr_addr <= a;
		sw_wr_data <= d;
		@(posedge mclk);
		sw_wr_en <= 1'b0;
		sw_wr_data <= ~d;
	endtask
	task automatic rd(input logic [19:0] a, input logic [31:0] exp);
		@(posedge mclk);
		sw_rd_en <= 1'b1;
		sw_rd_addr <= a;
		@(posedge mclk);
		sw_rd_en <= 1'b0;
		#1;
		cmp("read valid", 32'h00000001, sw_rd_valid);
		cmp("read data", exp, sw_rd_data);
	endtask
	// one cycle wide, the way the pipe timing raises them
	task automatic pulse(input bit sync);
		@(posedge mclk);
		vsync <= sync;
		vblank <= !sync;
		@(posedge mclk);
		vsync <= 1'b0;
		vblank <= 1'b0;
		tick(3);
	endtask
	task automatic pix(input logic [23:0] d, input logic exp);
		@(posedge mclk);
		pix_valid <= 1'b1;
		pix_data <= d;
		@(posedge mclk);
		pix_valid <= 1'b0;
		pix_data <= ~d;
		#1;
		cmp("pixel valid", 32'h00000001, pix_out_valid);
		cmp("transparent", {31'h0, exp}, pix_transparent);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		foreach (offs[i]) rd(offs[i], (i == 6) ? `SPR_RST_FLPQ : 32'h00000000);
		foreach (offs[i]) wr(offs[i], 32'hffffffff);
		foreach (offs[i]) rd(offs[i], full[i]);
		rd(20'h71190, 32'h00000000);
		// legal stride, linear offset and surface values replace the all-ones pattern before anything commits
		wr(`SPR_OFF_STRIDE, 32'h00004000);
		wr(`SPR_OFF_LIN, 32'h00000040);
		wr(`SPR_OFF_SURF, 32'h1ffc0000);
		rd(`SPR_OFF_FLPQ, 32'h00000602);
		cmp("first pixel", 32'h00000000, first_pix_addr);
		cmp("stride", 32'h00000000, stride_out);
		$display("test registers done");
		pulse(1'b0);
		cmp("stride", 32'h00004000, stride_out);
		cmp("first pixel", 32'h1ffc0000, first_pix_addr);
		cmp("tile x", 32'h00000000, tile_x_out);
		rd(`SPR_OFF_FLPQ, 32'h00000800);
		pulse(1'b1);
		cmp("first pixel", 32'h1ffc0040, first_pix_addr);
		$display("test flip done");
		@(posedge mclk);
		ctl_tiled <= 1'b1;
		ctl_rotate180 <= 1'b1;
		fork
			cs_u.load(`SPR_OFF_TILE, 32'h00120034, ok);
			wr(`SPR_OFF_LIN, 32'h00000080);
		join
		tick(2);
		cmp("load taken", 32'h00000001, ok);
		cmp("first pixel", 32'h1ffc0000, first_pix_addr);
		cmp("tile x", 32'h00000fff, tile_x_out);
		cmp("lower right", 32'h00000001, tile_from_lr);
		pulse(1'b0);
		cmp("tile x", 32'h00000034, tile_x_out);
		cmp("tile y", 32'h00000012, tile_y_out);
		rd(`SPR_OFF_LIN, 32'h00000080);
		$display("test tiled done");
		@(posedge mclk);
		ctl_tiled <= 1'b0;
		ctl_key_enable <= 1'b1;
		wr(`SPR_OFF_KEYVAL, 32'h00123456);
		wr(`SPR_OFF_KEYMSK, 32'h00ff00ff);
		pix(24'hffffff, 1'b1);
		wr(`SPR_OFF_SURF, 32'h00000000);
		pulse(1'b0);
		cmp("first pixel", 32'h00000040, first_pix_addr);
		pix(24'h125556, 1'b1);
		pix(24'h133456, 1'b0);
		@(posedge mclk);
		ctl_key_enable <= 1'b0;
		pix(24'h123456, 1'b0);
		$display("test key done");
		@(posedge mclk);
		pipe_enabled <= 1'b0;
		wr(`SPR_OFF_STRIDE, 32'h00000200);
		wr(`SPR_OFF_LIN, 32'h00000040);
		wr(`SPR_OFF_SURF, 32'h00020000);
		tick(2);
		cmp("stride", 32'h00000200, stride_out);
		cmp("first pixel", 32'h00020040, first_pix_addr);
		$display("test pipe off done");
		@(posedge mclk);
		pipe_enabled <= 1'b1;
		wr(`SPR_OFF_SURF, 32'h00040000);
		rd(`SPR_OFF_FLPQ, 32'h00000701);
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rd(`SPR_OFF_FLPQ, `SPR_RST_FLPQ);
		rd(`SPR_OFF_SURF, 32'h00000000);
		$display("test reset done");
		complete_run();
	end
endmodule // secondary_plane_surface_regs_test
`default_nettype wire

// file: spr_consts.vh
// spr_consts.vh: offsets, field positions, reset values and widths for the
// second plane surface register bank.
// assumes: included by bare name from the plane register bank files.
`ifndef SPR_CONSTS_VH
`define SPR_CONSTS_VH

// ----------------------------------------------------------------------
// register address width and byte offsets
// ----------------------------------------------------------------------
`define SPR_ADDR_W          20
`define SPR_OFF_LIN         20'h71184
`define SPR_OFF_STRIDE      20'h71188
`define SPR_OFF_KEYVAL      20'h71194
`define SPR_OFF_KEYMSK      20'h71198
`define SPR_OFF_SURF        20'h7119c
`define SPR_OFF_TILE        20'h711a4
`define SPR_OFF_FLPQ        20'h71200

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SPR_RST_LIN         32'h00000000
`define SPR_RST_STRIDE      32'h00000000
`define SPR_RST_KEY         24'h000000
`define SPR_RST_SURF        17'h00000
`define SPR_RST_TILE        12'h000
`define SPR_RST_FLPQ        32'h00000800
`define SPR_RST_OCC         8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SPR_KEY_MSB         23
`define SPR_SURF_MSB        28
`define SPR_SURF_LSB        12
`define SPR_TILE_Y_MSB      27
`define SPR_TILE_Y_LSB      16
`define SPR_TILE_X_MSB      11
`define SPR_TILE_X_LSB      0
`define SPR_FLPQ_FREE_MSB   15
`define SPR_FLPQ_FREE_LSB   8
`define SPR_FLPQ_OCC_MSB    7
`define SPR_FLPQ_OCC_LSB    0
`define SPR_CTL_TILED_BIT   10

// ----------------------------------------------------------------------
// flip queue
// ----------------------------------------------------------------------
`define SPR_FLPQ_DEPTH      8

`endif

// file: spr_key_cmp.v
// spr_key_cmp.v: colour key comparison of one sprite pixel.
// assumes: pixel, key and mask are all red/green/blue packed, same width.
`default_nettype none

module spr_key_cmp #(
	parameter W = 24
) (
	input  wire [W-1:0] pixel,     // sprite source pixel
	input  wire [W-1:0] key_value, // key colour
	input  wire [W-1:0] key_mask,  // one = bit takes part in compare
	output wire         is_match   // pixel matches the key
);

	// mismatch in a masked-out bit is ignored
	assign is_match = ~|((pixel ^ key_value) & key_mask);

endmodule // spr_key_cmp

`default_nettype wire

// file: spr_regs.v
// spr_regs.v: double buffered surface register bank of the second plane.
// assumes: vsync, vblank and plane control bits come from logic on mclk;
// register port and command stream port are on mclk too.
`default_nettype none
`include "spr_consts.vh"

module spr_regs #(
	parameter AW    = `SPR_ADDR_W,     // register address width
	parameter DEPTH = `SPR_FLPQ_DEPTH  // flip queue entries
) (
	input  wire          mclk,           // clock, 10 MHz
	input  wire          nrst,           // synchronous reset, active low
	input  wire          sw_wr_en,       // software register write strobe
	input  wire [AW-1:0] sw_wr_addr,     // software write byte address
	input  wire [31:0]   sw_wr_data,     // software write data
	input  wire          sw_rd_en,       // software register read strobe
	input  wire [AW-1:0] sw_rd_addr,     // software read byte address
	output reg  [31:0]   sw_rd_data,     // read data, one cycle after strobe
	output reg           sw_rd_valid,    // read data valid pulse
	input  wire          cs_wr_valid,    // command stream register load
	input  wire [AW-1:0] cs_wr_addr,     // command stream byte address
	input  wire [31:0]   cs_wr_data,     // command stream data
	output wire          cs_wr_ready,    // load taken this cycle
	input  wire          vsync,          // pipe vertical sync level
	input  wire          vblank,         // pipe vertical blank level
	input  wire          pipe_enabled,   // pipe driving this plane runs
	input  wire          ctl_tiled,      // plane control tiled surface bit
	input  wire          ctl_key_enable, // plane control source key enable
	input  wire          ctl_rotate180,  // plane control 180 degree rotation
	input  wire          pix_valid,      // sprite pixel strobe
	input  wire [23:0]   pix_data,       // sprite pixel, red green blue
	output reg  [31:0]   first_pix_addr, // aperture address of first pixel
	output reg  [31:0]   stride_out,     // active stride in bytes
	output reg  [11:0]   tile_x_out,     // active tiled x start, pixels
	output reg  [11:0]   tile_y_out,     // active tiled y start, lines
	output reg           tile_from_lr,   // x/y mark the lower right corner
	output reg           pix_transparent,// pixel keyed out
	output reg           pix_out_valid   // qualifies pix_transparent
);

	// ----------------------------------------------------------------------
	// write port merge
	// ----------------------------------------------------------------------
	// software wins; a command stream load waits while sw_wr_en is high
	assign cs_wr_ready = ~sw_wr_en;

	wire          wr_en   = sw_wr_en | cs_wr_valid;
	wire [AW-1:0] wr_addr = sw_wr_en ? sw_wr_addr : cs_wr_addr;
	wire [31:0]   wr_data = sw_wr_en ? sw_wr_data : cs_wr_data;

	wire wr_lin    = wr_en && (wr_addr == `SPR_OFF_LIN);
	wire wr_stride = wr_en && (wr_addr == `SPR_OFF_STRIDE);
	wire wr_keyval = wr_en && (wr_addr == `SPR_OFF_KEYVAL);
	wire wr_keymsk = wr_en && (wr_addr == `SPR_OFF_KEYMSK);
	wire wr_surf   = wr_en && (wr_addr == `SPR_OFF_SURF);
	wire wr_tile   = wr_en && (wr_addr == `SPR_OFF_TILE);

	// ----------------------------------------------------------------------
	// timing events
	// ----------------------------------------------------------------------
	reg vsync_q;
	reg vblank_q;

	always @(posedge mclk) begin
		if (!nrst) begin
			vsync_q  <= 1'b0;
			vblank_q <= 1'b0;
		end else begin
			vsync_q  <= vsync;
			vblank_q <= vblank;
		end
	end

	wire vsync_rise  = vsync & ~vsync_q;
	wire vblank_rise = vblank & ~vblank_q;
	wire load_vsync  = vsync_rise | ~pipe_enabled;
	wire load_vblank = vblank_rise | ~pipe_enabled;

	// ----------------------------------------------------------------------
	// pending (software visible) registers
	// ----------------------------------------------------------------------
	reg [31:0] lin_q;
	reg [31:0] stride_q;
	reg [23:0] keyval_q;
	reg [23:0] keymsk_q;
	reg [16:0] surf_q;
	reg [11:0] tile_x_q;
	reg [11:0] tile_y_q;

	always @(posedge mclk) begin
		if (!nrst) begin
			lin_q    <= `SPR_RST_LIN;
			stride_q <= `SPR_RST_STRIDE;
			keyval_q <= `SPR_RST_KEY;
			keymsk_q <= `SPR_RST_KEY;
			surf_q   <= `SPR_RST_SURF;
			tile_x_q <= `SPR_RST_TILE;
			tile_y_q <= `SPR_RST_TILE;
		end else begin
			if (wr_lin)
				lin_q <= wr_data;
			if (wr_stride)
				stride_q <= wr_data;
			if (wr_keyval)
				keyval_q <= wr_data[`SPR_KEY_MSB:0];
			if (wr_keymsk)
				keymsk_q <= wr_data[`SPR_KEY_MSB:0];
			if (wr_surf)
				surf_q <= wr_data[`SPR_SURF_MSB:`SPR_SURF_LSB];
			if (wr_tile) begin
				tile_y_q <= wr_data[`SPR_TILE_Y_MSB:`SPR_TILE_Y_LSB];
				tile_x_q <= wr_data[`SPR_TILE_X_MSB:`SPR_TILE_X_LSB];
			end
		end
	end

	// ----------------------------------------------------------------------
	// flip arming and queue occupancy
	// ----------------------------------------------------------------------
	reg        flip_armed_q;
	reg [7:0]  occ_q;
	reg [7:0]  occ_d;
	wire       flip_commit = flip_armed_q & load_vblank;

	// a surface write landing on the commit cycle re-arms: set beats clear
	always @(posedge mclk) begin
		if (!nrst)
			flip_armed_q <= 1'b0;
		else if (wr_surf)
			flip_armed_q <= 1'b1;
		else if (flip_commit)
			flip_armed_q <= 1'b0;
	end

	// occupancy saturates at DEPTH: further surface writes before a commit
	// go uncounted, so status never shows more than DEPTH occupied entries
	// every queued flip drains together at the commit
	always @* begin
		occ_d = occ_q;
		if (flip_commit)
			occ_d = wr_surf ? 8'h01 : 8'h00;
		else if (wr_surf && (occ_q < DEPTH[7:0]))
			occ_d = occ_q + 8'h01;
	end

	always @(posedge mclk) begin
		if (!nrst)
			occ_q <= `SPR_RST_OCC;
		else
			occ_q <= occ_d;
	end

	// ----------------------------------------------------------------------
	// active registers
	// ----------------------------------------------------------------------
	reg [31:0] lin_act_q;
	reg [31:0] stride_act_q;
	reg [23:0] keyval_act_q;
	reg [23:0] keymsk_act_q;
	reg [16:0] surf_act_q;
	reg [11:0] tile_x_act_q;
	reg [11:0] tile_y_act_q;

	always @(posedge mclk) begin
		if (!nrst) begin
			lin_act_q    <= `SPR_RST_LIN;
			stride_act_q <= `SPR_RST_STRIDE;
			keyval_act_q <= `SPR_RST_KEY;
			keymsk_act_q <= `SPR_RST_KEY;
			surf_act_q   <= `SPR_RST_SURF;
			tile_x_act_q <= `SPR_RST_TILE;
			tile_y_act_q <= `SPR_RST_TILE;
		end else begin
			if (load_vsync)
				lin_act_q <= lin_q;
			if (load_vblank) begin
				tile_x_act_q <= tile_x_q;
				tile_y_act_q <= tile_y_q;
			end
			if (flip_commit) begin
				surf_act_q   <= surf_q;
				stride_act_q <= stride_q;
				keyval_act_q <= keyval_q;
				keymsk_act_q <= keymsk_q;
			end
		end
	end

	// ----------------------------------------------------------------------
	// plane outputs
	// ----------------------------------------------------------------------
	// base is an aperture offset; page translation happens downstream
	wire [31:0] surf_addr = {3'h0, surf_act_q, 12'h000};

	always @(posedge mclk) begin
		if (!nrst) begin
			first_pix_addr <= 32'h00000000;
			stride_out     <= `SPR_RST_STRIDE;
			tile_x_out     <= `SPR_RST_TILE;
			tile_y_out     <= `SPR_RST_TILE;
			tile_from_lr   <= 1'b0;
		end else begin
			stride_out <= stride_act_q;
			if (ctl_tiled) begin
				first_pix_addr <= surf_addr;
				tile_x_out     <= tile_x_act_q;
				tile_y_out     <= tile_y_act_q;
			end else begin
				first_pix_addr <= surf_addr + lin_act_q;
				tile_x_out     <= 12'h000;
				tile_y_out     <= 12'h000;
			end
			// under rotation of a tiled surface x/y name the lower right corner
			tile_from_lr <= ctl_tiled & ctl_rotate180;
		end
	end

	// ----------------------------------------------------------------------
	// colour key
	// ----------------------------------------------------------------------
	wire key_hit;

	spr_key_cmp #(
		.W (24)
	) u_key (
		.pixel     (pix_data),
		.key_value (keyval_act_q),
		.key_mask  (keymsk_act_q),
		.is_match  (key_hit)
	);

	always @(posedge mclk) begin
		if (!nrst) begin
			pix_transparent <= 1'b0;
			pix_out_valid   <= 1'b0;
		end else begin
			pix_out_valid   <= pix_valid;
			pix_transparent <= pix_valid & ctl_key_enable & key_hit;
		end
	end

	// ----------------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------------
	reg  [31:0] rd_mux;
	wire [7:0]  free_cnt = DEPTH[7:0] - occ_q;

	// free count is derived, so free plus occupied always equals DEPTH
	// pending values read back, not active ones
	always @* begin
		case (sw_rd_addr)
			`SPR_OFF_LIN:    rd_mux = lin_q;
			`SPR_OFF_STRIDE: rd_mux = stride_q;
			`SPR_OFF_KEYVAL: rd_mux = {8'h00, keyval_q};
			`SPR_OFF_KEYMSK: rd_mux = {8'h00, keymsk_q};
			`SPR_OFF_SURF:   rd_mux = {3'h0, surf_q, 12'h000};
			`SPR_OFF_TILE:   rd_mux = {4'h0, tile_y_q, 4'h0, tile_x_q};
			`SPR_OFF_FLPQ:   rd_mux = {16'h0000, free_cnt, occ_q};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			sw_rd_data  <= 32'h00000000;
			sw_rd_valid <= 1'b0;
		end else begin
			sw_rd_valid <= sw_rd_en;
			if (sw_rd_en)
				sw_rd_data <= rd_mux;
		end
	end

endmodule // spr_regs

`default_nettype wire

// file: spsr_cs_model.sv
// spsr_cs_model.sv: command streamer side, issuing register loads.
// assumes: shares mclk with the bank; a load waits up to 8 cycles for cs_wr_ready.
`default_nettype none
// ------
// loader
// ------
module spsr_cs_model (
	input  wire logic        mclk,        // clock
	input  wire logic        cs_wr_ready, // load taken
	output var  logic        cs_wr_valid, // load request
	output var  logic [19:0] cs_wr_addr,  // byte address
	output var  logic [31:0] cs_wr_data   // load data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs_wr_valid = 1'b0;
		cs_wr_addr = 20'h00000;
		cs_wr_data = 32'h00000000;
	end
	// released lines show the inverse, so stale data is never mistaken for valid
	task automatic load(input logic [19:0] a, input logic [31:0] d, output bit ok);
		int i;
		@(posedge mclk);
		cs_wr_valid <= 1'b1;
		cs_wr_addr <= a;
		cs_wr_data <= d;
		ok = 1'b0;
		for (i = 0; i < 8 && !ok; i++) begin
			@(posedge mclk);
			ok = cs_wr_ready;
		end
		cs_wr_valid <= 1'b0;
		cs_wr_addr <= ~a;
		cs_wr_data <= ~d;
	endtask
endmodule // spsr_cs_model
`default_nettype wire

// file: spsr_properties.sv
// spsr_properties.sv: port checks of the plane register bank.
// assumes: bound onto spr_regs; one clock, synchronous low reset.
`default_nettype none
`include "spr_consts.vh"
// ------
// checker
// ------
module spsr_props #(
	parameter AW    = 20, // addr width
	parameter DEPTH = 8   // queue depth
) (
	input wire logic          mclk,            // clock
	input wire logic          nrst,            // reset
	input wire logic          sw_wr_en,        // write strobe
	input wire logic          sw_rd_en,        // read strobe
	input wire logic [AW-1:0] sw_rd_addr,      // read addr
	input wire logic [31:0]   sw_rd_data,      // read data
	input wire logic          cs_wr_ready,     // load ready
	input wire logic          vsync,           // sync level
	input wire logic          vblank,          // blank level
	input wire logic          pipe_enabled,    // pipe runs
	input wire logic          ctl_tiled,       // tiled bit
	input wire logic          ctl_key_enable,  // key enable
	input wire logic          ctl_rotate180,   // rotation
	input wire logic [31:0]   first_pix_addr,  // first pixel
	input wire logic [31:0]   stride_out,      // stride
	input wire logic [11:0]   tile_x_out,      // tile x
	input wire logic [11:0]   tile_y_out,      // tile y
	input wire logic          tile_from_lr,    // corner mode
	input wire logic          pix_transparent, // keyed out
	input wire logic          pix_out_valid    // pixel valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	property p_q_sum;
		sw_rd_en && sw_rd_addr == `SPR_OFF_FLPQ |=> sw_rd_data[31:16] == 0
			&& sw_rd_data[15:8] + sw_rd_data[7:0] == DEPTH;
	endproperty
	a_q_sum: assert property (p_q_sum) else $error("queue counts off");
	property p_key_rsvd;
		sw_rd_en && (sw_rd_addr == `SPR_OFF_KEYVAL || sw_rd_addr == `SPR_OFF_KEYMSK)
			|=> sw_rd_data[31:24] == 8'h00;
	endproperty
	a_key_rsvd: assert property (p_key_rsvd) else $error("key top byte set");
	property p_cs_ready;
		cs_wr_ready == !sw_wr_en;
	endproperty
	a_cs_ready: assert property (p_cs_ready) else $error("load ready wrong");
	property p_key_gate;
		pix_transparent |-> pix_out_valid && $past(ctl_key_enable);
	endproperty
	a_key_gate: assert property (p_key_gate) else $error("keyed while off");
	property p_lin_tile;
		!$past(ctl_tiled) |-> tile_x_out == 12'h000 && tile_y_out == 12'h000;
	endproperty
	a_lin_tile: assert property (p_lin_tile) else $error("tile used linear");
	property p_corner;
		$past(nrst) |-> tile_from_lr == ($past(ctl_tiled) && $past(ctl_rotate180));
	endproperty
	a_corner: assert property (p_corner) else $error("corner mode wrong");
	property p_stride_hold;
		(pipe_enabled && !vblank) [*4] |=> $stable(stride_out);
	endproperty
	a_stride_hold: assert property (p_stride_hold) else $error("stride moved");
	property p_lin_hold;
		(pipe_enabled && !vsync && !vblank && !ctl_tiled) [*4] |=> $stable(first_pix_addr);
	endproperty
	a_lin_hold: assert property (p_lin_hold) else $error("offset moved");
endmodule // spsr_props
bind spr_regs spsr_props #(.AW(AW), .DEPTH(DEPTH)) chk_u (.mclk, .nrst, .sw_wr_en,
	.sw_rd_en, .sw_rd_addr, .sw_rd_data, .cs_wr_ready, .vsync, .vblank, .pipe_enabled,
	.ctl_tiled, .ctl_key_enable, .ctl_rotate180, .first_pix_addr, .stride_out,
	.tile_x_out, .tile_y_out, .tile_from_lr, .pix_transparent, .pix_out_valid);
`default_nettype wire
